/* File: core/adc_pwr_host.sv */
// Host-side controller for converter power-save and reads
// Assumes the converter end shares the clock; read_req is a single-cycle pulse, sleep, convert and nap_after are held levels
module adc_pwr_host
  import adc_pwr_pkg::*;
#(
  parameter int unsigned RESUME_CYCLES = RESUME_TOTAL_CYC,
  parameter int unsigned SETTLE_CYCLES = REF_SETTLE_CYC,
  parameter int unsigned ACQ_CYCLES    = 8,
  parameter int unsigned NAP_EXTRA     = 20
) (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                clock_enable,
  input  wire logic                sleep,
  input  wire logic                convert,
  input  wire logic                nap_after,
  input  wire logic                read_req,
  output logic                     accurate,
  output logic                     read_valid,
  output logic [RESULT_W-1:0]      read_data,
  adc_pwr_if.host                  link
);
  // ************************************************************
  // Control registers
  // ************************************************************
  logic                pd_r,   pd_nxt;
  logic                cs_r,   cs_nxt;
  logic [31:0]         res_r,  res_nxt;
  logic [31:0]         acq_r,  acq_nxt;
  logic [3:0]          qz_r,   qz_nxt;
  logic [31:0]         set_r,  set_nxt;
  logic                trim_d_r;
  logic                busy_d_r;
  logic                acc_r,  acc_nxt;
  logic                rv_r,   rv_nxt;
  logic [RESULT_W-1:0] rd_r,   rd_nxt;
  logic                hold_r, hold_nxt;

  always_comb begin
    pd_nxt   = pd_r;
    cs_nxt   = 1'b1;
    res_nxt  = res_r;
    acq_nxt  = (acq_r != 32'h0) ? acq_r - 32'h1 : acq_r;
    qz_nxt   = (qz_r != 4'h0) ? qz_r - 4'h1 : qz_r;
    set_nxt  = (set_r != 32'h0) ? set_r - 32'h1 : set_r;
    acc_nxt  = acc_r;
    rv_nxt   = 1'b0;
    rd_nxt   = rd_r;
    hold_nxt = hold_r;
    if (sleep) begin
      pd_nxt  = 1'b1;
      acc_nxt = 1'b0;
    end else if (pd_r) begin
      pd_nxt  = 1'b0;
      res_nxt = RESUME_CYCLES;
    end
    if (res_r != 32'h0) begin
      res_nxt = res_r - 32'h1;
    end else if (!pd_r && !link.trim_loading && !sleep && set_r == 32'h0) begin
      acc_nxt = 1'b1;
    end
    if (trim_d_r && !link.trim_loading) begin
      set_nxt = 32'(SETTLE_CYCLES);
    end
    if (link.napping) begin
      acq_nxt = 32'(ACQ_CYCLES + NAP_EXTRA);
    end
    if (busy_d_r && !link.busy) begin
      qz_nxt = 4'(QUIET_CYC + 1);
    end
    if (!link.busy) begin
      hold_nxt = ~nap_after;
    end
    if (read_req && !link.busy && qz_r == 4'h0 && !busy_d_r) begin
      cs_nxt = 1'b0;
      rv_nxt = 1'b1;
      rd_nxt = link.result;
    end
  end

  assign link.qualified_convert_start = ~(convert && acq_r == 32'h0 && !pd_r) & hold_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      pd_r     <= 1'b1;
      cs_r     <= 1'b1;
      res_r    <= 32'h0;
      acq_r    <= 32'h0;
      qz_r     <= 4'h0;
      set_r    <= 32'h0;
      trim_d_r <= 1'b1;
      busy_d_r <= 1'b0;
      acc_r    <= 1'b0;
      rv_r     <= 1'b0;
      rd_r     <= RESULT_RST;
      hold_r   <= 1'b1;
    end else if (clock_enable) begin
      pd_r     <= pd_nxt;
      cs_r     <= cs_nxt;
      res_r    <= res_nxt;
      acq_r    <= acq_nxt;
      qz_r     <= qz_nxt;
      set_r    <= set_nxt;
      trim_d_r <= link.trim_loading;
      busy_d_r <= link.busy;
      acc_r    <= acc_nxt;
      rv_r     <= rv_nxt;
      rd_r     <= rd_nxt;
      hold_r   <= hold_nxt;
    end
  end

  assign link.power_down_request = pd_r;
  assign link.chip_select_n      = cs_r;
  assign link.frame_sync         = 1'b1;
  assign accurate                = acc_r;
  assign read_valid              = rv_r;
  assign read_data               = rd_r;
endmodule

/* File: pkg/adc_pwr_pkg.sv */
// Shared constants for the power-save control link between host and converter
// Assumes a single 100 MHz clock shared by both ends
package adc_pwr_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned RESULT_W         = 18;
  // Times in their own units
  localparam int unsigned PD_ENTRY_US      = 10;
  localparam int unsigned NAP_ENTRY_NS     = 200;
  localparam int unsigned RESUME_TOTAL_MS  = 25;
  localparam int unsigned REF_SETTLE_MS    = 4;
  localparam int unsigned CONV_NS          = 1160;
  localparam int unsigned QUIET_NS         = 50;
  // Cycle counts (longest times round down, least times round up)
  localparam int unsigned PD_ENTRY_CYC     = PD_ENTRY_US * CLK_MHZ;
  localparam int unsigned NAP_ENTRY_CYC    = (NAP_ENTRY_NS * CLK_MHZ) / 1000;
  localparam int unsigned RESUME_TOTAL_CYC = RESUME_TOTAL_MS * 1000 * CLK_MHZ;
  localparam int unsigned REF_SETTLE_CYC   = REF_SETTLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned CONV_CYC         = (CONV_NS * CLK_MHZ) / 1000;
  localparam int unsigned QUIET_CYC        = (QUIET_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TRIM_CONVS       = 2;
  localparam int unsigned PD_ENTRY_DLY     = 2;
  localparam int unsigned NAP_ENTRY_DLY    = 1;
  localparam logic [17:0] RESULT_RST       = 18'h00000;
endpackage

/* File: pkg/adc_pwr_if.sv */
// Link between host controller and converter power-save control
// Assumes both ends run on the same clock
interface adc_pwr_if;
  logic                 power_down_request;
  logic                 qualified_convert_start;
  logic                 chip_select_n;
  logic                 frame_sync;
  logic                 busy;
  logic                 napping;
  logic                 powered_down;
  logic                 trim_loading;
  logic                 sdo_oe;
  logic [17:0]          result;
  modport dev  (input power_down_request, qualified_convert_start, chip_select_n, frame_sync,
                output busy, napping, powered_down, trim_loading, sdo_oe, result);
  modport host (output power_down_request, qualified_convert_start, chip_select_n, frame_sync,
                input busy, napping, powered_down, trim_loading, sdo_oe, result);
endinterface

/* File: core/adc_pwr_dev.sv */
// Converter-side power-save, nap and result update control
// Assumes host-driven inputs are on the same clock; sample is the analog stand-in value
module adc_pwr_dev
  import adc_pwr_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYC
) (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                clock_enable,
  input  wire logic [RESULT_W-1:0] sample,
  adc_pwr_if.dev                   link
);
  // ************************************************************
  // State machine
  // ************************************************************
  typedef enum logic [4:0] {
    S_OFF  = 5'b00001,
    S_WAIT = 5'b00010,
    S_CONV = 5'b00100,
    S_NAP  = 5'b01000,
    S_ACQ  = 5'b10000
  } dev_state_t;

  dev_state_t          state_r,   state_nxt;
  logic [10:0]         cnt_r,     cnt_nxt;
  logic [1:0]          trim_r,    trim_nxt;
  logic [RESULT_W-1:0] result_r,  result_nxt;
  logic                start_d_r, start_d_nxt;
  logic                pd_r,      pd_nxt;
  logic                start_fall;

  assign start_fall = start_d_r & ~link.qualified_convert_start;

  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    trim_nxt    = trim_r;
    result_nxt  = result_r;
    start_d_nxt = link.qualified_convert_start;
    pd_nxt      = link.power_down_request;
    if (pd_r && state_r != S_OFF) begin
      state_nxt = S_OFF;
      trim_nxt  = 2'(TRIM_CONVS);
    end else begin
      case (state_r)
        S_OFF: begin
          if (!pd_r) begin
            state_nxt = S_WAIT;
          end
        end
        S_WAIT, S_ACQ: begin
          if (start_fall) begin
            state_nxt = S_CONV;
            cnt_nxt   = 11'(CONV_CYCLES);
          end
        end
        S_CONV: begin
          if (cnt_r > 11'h001) begin
            cnt_nxt = cnt_r - 11'h001;
          end else begin
            result_nxt = sample;
            if (trim_r != 2'h0) begin
              trim_nxt = trim_r - 2'h1;
            end
            if (!link.qualified_convert_start) begin
              state_nxt = S_NAP;
            end else begin
              state_nxt = S_WAIT;
            end
          end
        end
        S_NAP: begin
          if (link.qualified_convert_start) begin
            state_nxt = S_ACQ;
          end
        end
        default: state_nxt = S_OFF;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r   <= S_OFF;
      cnt_r     <= 11'h000;
      trim_r    <= 2'(TRIM_CONVS);
      result_r  <= RESULT_RST;
      start_d_r <= 1'b1;
      pd_r      <= 1'b1;
    end else if (clock_enable) begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      trim_r    <= trim_nxt;
      result_r  <= result_nxt;
      start_d_r <= start_d_nxt;
      pd_r      <= pd_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign link.busy         = (state_r == S_CONV);
  assign link.napping      = (state_r == S_NAP);
  assign link.powered_down = (state_r == S_OFF);
  assign link.trim_loading = (trim_r != 2'h0);
  assign link.sdo_oe       = (state_r != S_OFF);
  assign link.result       = result_r;
endmodule

/* File: verif/adc_pwr_sva.sv */
// Assertions on the host-to-converter power-save link
// Assumes one clock and a synchronous active-high reset shared by both ends
module adc_pwr_sva
  import adc_pwr_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        power_down_request,
  input wire logic        qualified_convert_start,
  input wire logic        chip_select_n,
  input wire logic        busy,
  input wire logic        napping,
  input wire logic        powered_down,
  input wire logic        trim_loading,
  input wire logic        sdo_oe,
  input wire logic [17:0] result
);
  // ****************
  // Link checks
  // ****************
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  chk_pd_entry: assert property ($rose(power_down_request) |-> ##[1:1000]
    (powered_down && !sdo_oe)) else $error("power-down not reached");
  chk_off_hiz: assert property (powered_down |-> !sdo_oe)
    else $error("output driven while off");
  chk_resume_on: assert property ($fell(power_down_request) |-> ##[1:4]
    (!powered_down && sdo_oe)) else $error("no resume");
  chk_result_busy: assert property ($changed(result) |-> $fell(busy))
    else $error("result changed off busy fall");
  chk_trim_set: assert property (powered_down |-> trim_loading)
    else $error("trim not pending while off");
  chk_nap_entry: assert property ($fell(busy) && !qualified_convert_start |->
    ##[1:20] (napping && sdo_oe)) else $error("nap not entered");
  chk_wait_phase: assert property ($fell(busy) && qualified_convert_start |=>
    !busy && !napping) else $error("wait phase not kept");
  chk_read_quiet: assert property ($fell(chip_select_n) |-> !busy && !$fell(busy))
    else $error("read in quiet zone");
  cover property ($rose(napping));
  cover property ($rose(powered_down));
  cover property ($fell(chip_select_n));
endmodule

/* File: verif/tb.sv */
// Bench joining host and converter ends through the link
// Assumes the shared package and interface are compiled first
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb
  import adc_pwr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Bench
  // ****************
  logic                clock = 0, reset = 1, sleep = 0, convert = 0, nap_after = 0;
  logic                read_req = 0, accurate, read_valid, prev_nap = 0;
  logic [RESULT_W-1:0] sample = '0, read_data, exp_v;
  logic [RESULT_W-1:0] exp_q[$];
  int                  seed = 32'h156a51b4, n_fail = 0, samples_checked = 0;
  int                  since_fall = 0, up_cyc = 0;
  always #5 clock = ~clock;
  adc_pwr_if adc_pwr_if_i ();
  adc_pwr_dev #(.CONV_CYCLES(10)) adc_pwr_dev_i (.clock(clock), .reset(reset),
    .clock_enable(1'b1), .sample(sample), .link(adc_pwr_if_i.dev));
  adc_pwr_host #(.RESUME_CYCLES(50), .SETTLE_CYCLES(10)) adc_pwr_host_i (.clock(clock),
    .reset(reset), .clock_enable(1'b1), .sleep(sleep), .convert(convert),
    .nap_after(nap_after), .read_req(read_req), .accurate(accurate),
    .read_valid(read_valid), .read_data(read_data), .link(adc_pwr_if_i.host));
  adc_pwr_sva adc_pwr_sva_i (.clock(clock), .reset(reset),
    .power_down_request(adc_pwr_if_i.power_down_request),
    .qualified_convert_start(adc_pwr_if_i.qualified_convert_start),
    .chip_select_n(adc_pwr_if_i.chip_select_n), .busy(adc_pwr_if_i.busy),
    .napping(adc_pwr_if_i.napping), .powered_down(adc_pwr_if_i.powered_down),
    .trim_loading(adc_pwr_if_i.trim_loading), .sdo_oe(adc_pwr_if_i.sdo_oe),
    .result(adc_pwr_if_i.result));
  always @(posedge clock) begin
    since_fall <= (adc_pwr_if_i.busy === 1'b0) ? since_fall + 1 : 0;
    up_cyc <= (adc_pwr_if_i.powered_down === 1'b1) ? 0 : up_cyc + 1;
  end
  always @(negedge clock) if (read_valid === 1'b1) begin
    exp_v = exp_q.pop_front();
    `CHK("read_data", exp_v, read_data)
  end
  function automatic logic pick(input int k);
    return (k == 0) ? adc_pwr_if_i.powered_down : (k == 1) ? adc_pwr_if_i.busy : accurate;
  endfunction
  task end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_on(input int k, input logic v);
    int n;
    for (n = 0; n < 3000 && pick(k) !== v; n++) @(negedge clock);
    if (n == 3000) begin
      n_fail++;
      $display("MISMATCH wait %0d exp %b got timeout", k, v);
      end_of_test();
    end
  endtask
  task automatic conv(input logic nap);
    nap_after = nap;
    sample = RESULT_W'($random(seed));
    convert = 1;
    wait_on(1, 1'b1);
    convert = 0;
    if (prev_nap) `CHK("nap_gap", 1'b1, since_fall >= 28)
    wait_on(1, 1'b0);
    repeat (3) @(negedge clock);
    `CHK("napping", nap, adc_pwr_if_i.napping)
    prev_nap = nap;
    repeat (8) @(negedge clock);
    exp_q.push_back(sample);
    read_req = 1;
    @(negedge clock);
    read_req = 0;
    repeat (12) @(negedge clock);
  endtask
  task automatic resume;
    wait_on(0, 1'b0);
    conv(0);
    `CHK("trim_first", 1'b1, adc_pwr_if_i.trim_loading)
    `CHK("early_accurate", 1'b0, accurate)
    conv(0);
    `CHK("trim_done", 1'b0, adc_pwr_if_i.trim_loading)
    wait_on(2, 1'b1);
    `CHK("resume_time", 1'b1, up_cyc >= 50)
  endtask
  initial begin
    repeat (6) @(negedge clock);
    reset = 0;
    resume();
    $display("test resume done");
    for (int i = 0; i < 6; i++) conv(i[0]);
    $display("test nap_wait done");
    sleep = 1;
    wait_on(0, 1'b1);
    `CHK("sdo_oe_off", 1'b0, adc_pwr_if_i.sdo_oe)
    `CHK("accurate_off", 1'b0, accurate)
    sleep = 0;
    resume();
    $display("test power_down done");
    end_of_test();
  end
endmodule
